// ===== core/wasc_pkg.sv
// package for the waveform auto-shutdown control block
// assumes a single 50 MHz clock domain and an AXI4-Lite register bus
package wasc_pkg;

  // ==========================================================
  // bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // register offsets
  localparam logic [AXI_ADDR_W-1:0] OFS_SHDN_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_OUT_CFG   = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_DRV_CFG   = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_MASK  = 8'h10;

  // ==========================================================
  // field positions
  localparam int BIT_EVENT_FLAG  = 7;
  localparam int BIT_AUTO_RST    = 6;
  localparam int BIT_CMP2_EN     = 3;
  localparam int BIT_CMP1_EN     = 2;
  localparam int BIT_FLT_EN      = 1;
  localparam int POS_B_STATE     = 6;
  localparam int POS_A_STATE     = 4;
  localparam int POS_SRC_SEL     = 0;
  localparam int POS_DEAD        = 0;
  localparam int BIT_POL_A       = 6;
  localparam int BIT_POL_B       = 7;
  localparam int BIT_IRQ_ENTER   = 0;
  localparam int BIT_IRQ_RESTART = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SHDN_CTRL = 8'h00;
  localparam logic [7:0] RST_OUT_CFG   = 8'h00;
  localparam logic [7:0] RST_DRV_CFG   = 8'h00;
  localparam logic [1:0] RST_IRQ       = 2'h0;
  localparam logic [5:0] DEAD_ZERO     = 6'h00;

  // ==========================================================
  // encodings
  localparam logic [1:0] SRC_CMP1 = 2'h0;
  localparam logic [1:0] SRC_CMP2 = 2'h1;
  localparam logic [1:0] SRC_WAV1 = 2'h2;
  localparam logic [1:0] SHDN_INACTIVE = 2'h0;
  localparam logic [1:0] SHDN_TRISTATE = 2'h1;
  localparam logic [1:0] SHDN_LOW      = 2'h2;
  localparam logic [1:0] SHDN_HIGH     = 2'h3;

  typedef struct packed {
    logic [1:0] shdn_state;
    logic       polarity;
    logic [5:0] dead_count;
  } wasc_chan_cfg_t;

  typedef enum logic [0:0] {WR_IDLE, WR_RESP} wasc_wr_state_t;
  typedef enum logic [0:0] {RD_IDLE, RD_DATA} wasc_rd_state_t;

endpackage

// ===== core/wasc_chan_drive.sv
// one complementary output channel: normal drive or shutdown state
// assumes shutdown is a registered level from the control block
`timescale 1ns/1ps
`default_nettype none
module wasc_chan_drive
  import wasc_pkg::*;
(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  var  wasc_chan_cfg_t cfg,
  input  wire logic           shutdown,
  input  wire logic           wave,
  output var  logic           pin_q,
  output var  logic           pin_oe_q
);

  // ==========================================================
  // dead-band delay before the inactive level
  logic [5:0] dead_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dead_q <= DEAD_ZERO;
    else if (!shutdown)
      dead_q <= cfg.dead_count;
    else if (dead_q != DEAD_ZERO)
      dead_q <= dead_q - 6'h01;
  end

  // ==========================================================
  // pin level and enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else if (!shutdown)
    begin
      pin_q    <= wave ^ cfg.polarity;
      pin_oe_q <= 1'b1;
    end
    else
    begin
      unique case (cfg.shdn_state)
        SHDN_HIGH:
        begin
          pin_q    <= 1'b1;
          pin_oe_q <= 1'b1;
        end
        SHDN_LOW:
        begin
          pin_q    <= 1'b0;
          pin_oe_q <= 1'b1;
        end
        SHDN_TRISTATE:
        begin
          pin_q    <= 1'b0;
          pin_oe_q <= 1'b0;
        end
        SHDN_INACTIVE:
        begin
          // old level holds through the dead band, then idle level
          if (dead_q == DEAD_ZERO)
          begin
            pin_q    <= cfg.polarity;
            pin_oe_q <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== core/wasc_top.sv
// waveform auto-shutdown control with AXI4-Lite registers
// assumes comparator and fault inputs are synchronous to aclk
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - comparator 2 high shuts down when enabled
// - comparator 1 high shuts down when enabled
// - fault pin low shuts down when enabled
// - source select 00 comparator 1, 01 comparator 2
// - flag set forces outputs to shutdown states
// - state 11 high, 10 low, 01 off, 00 idle
module wasc_top
  import wasc_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  output var  logic [1:0]              s_axi_bresp,
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  output var  logic [AXI_DATA_W-1:0]   s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    comparator1_async_output,
  input  wire logic                    comparator2_async_output,
  input  wire logic                    wave1_in,
  input  wire logic                    wave2_in,
  input  wire logic                    fault_input_pin_n,
  output var  logic                    out_a_q,
  output var  logic                    out_a_oe_q,
  output var  logic                    out_b_q,
  output var  logic                    out_b_oe_q,
  output var  logic                    irq_q
);

  // ==========================================================
  // helpers
  function automatic logic reg_known(input logic [AXI_ADDR_W-1:0] a);
    reg_known = (a == OFS_SHDN_CTRL) || (a == OFS_OUT_CFG) || (a == OFS_DRV_CFG)
             || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  // ==========================================================
  // state
  logic [7:0]      shdn_ctrl_q;
  logic [7:0]      out_cfg_q;
  logic [7:0]      drv_cfg_q;
  logic [1:0]      irq_stat_q;
  logic [1:0]      irq_mask_q;
  wasc_wr_state_t  wr_state_q;
  wasc_rd_state_t  rd_state_q;
  logic            aw_have_q;
  logic            w_have_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [7:0]      wbyte_q;
  logic            wlane_q;

  logic            aw_take;
  logic            w_take;
  logic            wr_fire;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [7:0]      wr_byte;
  logic            wr_lane;
  logic            rd_take;
  logic            stat_rd;
  logic            shdn_req;
  logic            flag_d;
  logic            src_level;
  logic [1:0]      irq_set;
  wasc_chan_cfg_t  cfg_a;
  wasc_chan_cfg_t  cfg_b;

  // ==========================================================
  // write channel handshake, address and data in either order
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (wr_state_q == WR_IDLE) && (aw_have_q || aw_take) && (w_have_q || w_take);
  assign wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
  assign wr_byte = w_have_q ? wbyte_q : s_axi_wdata[7:0];
  assign wr_lane = w_have_q ? wlane_q : s_axi_wstrb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_q    <= WR_IDLE;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wbyte_q       <= 8'h00;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      unique case (wr_state_q)
        WR_IDLE:
        begin
          if (aw_take)
          begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
          end
          if (w_take)
          begin
            w_have_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
          end
          s_axi_awready <= !(aw_have_q || aw_take);
          s_axi_wready  <= !(w_have_q || w_take);
          if (wr_fire)
          begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= reg_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            wr_state_q    <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state_q   <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // read channel; a read of the interrupt status clears it
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_take && (s_axi_araddr == OFS_IRQ_STAT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_q    <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      unique case (rd_state_q)
        RD_IDLE:
        begin
          s_axi_arready <= 1'b1;
          if (rd_take)
          begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata   <= '0;
            unique case (s_axi_araddr)
              OFS_SHDN_CTRL: s_axi_rdata[7:0] <= shdn_ctrl_q;
              OFS_OUT_CFG:   s_axi_rdata[7:0] <= out_cfg_q;
              OFS_DRV_CFG:   s_axi_rdata[7:0] <= drv_cfg_q;
              OFS_IRQ_STAT:  s_axi_rdata[1:0] <= irq_stat_q;
              OFS_IRQ_MASK:  s_axi_rdata[1:0] <= irq_mask_q;
              default:       s_axi_rdata      <= '0;
            endcase
            rd_state_q <= RD_DATA;
          end
        end
        RD_DATA:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rd_state_q   <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // shutdown sources and event flag
  always_comb
  begin
    shdn_req = 1'b0;
    if (shdn_ctrl_q[BIT_CMP2_EN] && comparator2_async_output)
      shdn_req = 1'b1;
    if (shdn_ctrl_q[BIT_CMP1_EN] && comparator1_async_output)
      shdn_req = 1'b1;
    if (shdn_ctrl_q[BIT_FLT_EN] && !fault_input_pin_n)
      shdn_req = 1'b1;
  end

  // a live source beats a software clear in the same cycle
  always_comb
  begin
    flag_d = shdn_ctrl_q[BIT_EVENT_FLAG];
    if (wr_fire && wr_lane && (wr_addr == OFS_SHDN_CTRL))
      flag_d = wr_byte[BIT_EVENT_FLAG];
    if (shdn_ctrl_q[BIT_AUTO_RST] && shdn_ctrl_q[BIT_EVENT_FLAG])
      flag_d = 1'b0;
    if (shdn_req)
      flag_d = 1'b1;
  end

  // ==========================================================
  // configuration registers; only byte lane 0 is implemented
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      shdn_ctrl_q <= RST_SHDN_CTRL;
    else
    begin
      shdn_ctrl_q[BIT_EVENT_FLAG] <= flag_d;
      if (wr_fire && wr_lane && (wr_addr == OFS_SHDN_CTRL))
      begin
        shdn_ctrl_q[BIT_AUTO_RST] <= wr_byte[BIT_AUTO_RST];
        shdn_ctrl_q[BIT_CMP2_EN]  <= wr_byte[BIT_CMP2_EN];
        shdn_ctrl_q[BIT_CMP1_EN]  <= wr_byte[BIT_CMP1_EN];
        shdn_ctrl_q[BIT_FLT_EN]   <= wr_byte[BIT_FLT_EN];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_cfg_q  <= RST_OUT_CFG;
      drv_cfg_q  <= RST_DRV_CFG;
      irq_mask_q <= RST_IRQ;
    end
    else if (wr_fire && wr_lane)
    begin
      if (wr_addr == OFS_OUT_CFG)
        out_cfg_q <= wr_byte & 8'hF3;
      if (wr_addr == OFS_DRV_CFG)
        drv_cfg_q <= wr_byte;
      if (wr_addr == OFS_IRQ_MASK)
        irq_mask_q <= wr_byte[1:0];
    end
  end

  // ==========================================================
  // interrupts: entry and automatic restart are sticky events
  always_comb
  begin
    irq_set = 2'h0;
    irq_set[BIT_IRQ_ENTER]   = flag_d && !shdn_ctrl_q[BIT_EVENT_FLAG];
    irq_set[BIT_IRQ_RESTART] = !flag_d && shdn_ctrl_q[BIT_EVENT_FLAG]
                               && shdn_ctrl_q[BIT_AUTO_RST];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= RST_IRQ;
    else
      irq_stat_q <= (stat_rd ? 2'h0 : irq_stat_q) | irq_set;
  end

  // one cycle late so the pin stays a plain flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_q & irq_mask_q);
  end

  // ==========================================================
  // waveform source and output channels
  always_comb
  begin
    unique case (out_cfg_q[POS_SRC_SEL +: 2])
      SRC_CMP1: src_level = comparator1_async_output;
      SRC_CMP2: src_level = comparator2_async_output;
      SRC_WAV1: src_level = wave1_in;
      default:  src_level = wave2_in;
    endcase
  end

  assign cfg_a = '{shdn_state: out_cfg_q[POS_A_STATE +: 2],
                   polarity:   drv_cfg_q[BIT_POL_A],
                   dead_count: drv_cfg_q[POS_DEAD +: 6]};
  assign cfg_b = '{shdn_state: out_cfg_q[POS_B_STATE +: 2],
                   polarity:   drv_cfg_q[BIT_POL_B],
                   dead_count: drv_cfg_q[POS_DEAD +: 6]};

  // B is the complement of A before polarity
  wasc_chan_drive u_chan_a (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cfg      (cfg_a),
    .shutdown (shdn_ctrl_q[BIT_EVENT_FLAG]),
    .wave     (src_level),
    .pin_q    (out_a_q),
    .pin_oe_q (out_a_oe_q)
  );

  wasc_chan_drive u_chan_b (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cfg      (cfg_b),
    .shutdown (shdn_ctrl_q[BIT_EVENT_FLAG]),
    .wave     (!src_level),
    .pin_q    (out_b_q),
    .pin_oe_q (out_b_oe_q)
  );

endmodule
`default_nettype wire

// ===== tb/wasc_chk_chk.sv
// assertion checker for the auto-shutdown control block
// assumes it is bound to wasc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module wasc_chk
  import wasc_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  comparator1_async_output,
  input wire logic                  comparator2_async_output,
  input wire logic                  fault_input_pin_n,
  input wire logic                  out_a_q,
  input wire logic                  out_a_oe_q,
  input wire logic                  out_b_q,
  input wire logic                  out_b_oe_q
);
  // ==========
  // register shadow, taken at the answer so it lags the design slightly
  logic [7:0] aw_q, w_q, ctl_q, cfg_q;
  logic       shdn_ok;
  function automatic logic st_ok(input logic [1:0] st, input logic p, input logic oe);
    st_ok = (st == SHDN_HIGH) ? (p && oe) : (st == SHDN_LOW) ? (!p && oe) : (st == SHDN_TRISTATE) ? !oe : 1'b1;
  endfunction
  assign shdn_ok = st_ok(cfg_q[POS_A_STATE+:2], out_a_q, out_a_oe_q)
                && st_ok(cfg_q[POS_B_STATE+:2], out_b_q, out_b_oe_q);
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      w_q <= s_axi_wdata[7:0];
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q <= 8'h00;
      cfg_q <= 8'h00;
    end
    else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY)
    begin
      if (aw_q == OFS_SHDN_CTRL)
        ctl_q <= w_q;
      if (aw_q == OFS_OUT_CFG)
        cfg_q <= w_q;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  aw_refuse_a:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("address taken twice");
  w_refuse_a:
    assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("data taken twice");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  cmp2_shdn_a:
    assert property (ctl_q[BIT_CMP2_EN] && comparator2_async_output |-> ##2 shdn_ok)
    else $error("no shutdown on comparator 2");
  cmp1_shdn_a:
    assert property (ctl_q[BIT_CMP1_EN] && comparator1_async_output |-> ##2 shdn_ok)
    else $error("no shutdown on comparator 1");
  flt_shdn_a:
    assert property (ctl_q[BIT_FLT_EN] && !fault_input_pin_n |-> ##2 shdn_ok)
    else $error("no shutdown on fault pin");
  tri_off_a:
    assert property ($fell(out_a_oe_q) && $past(aresetn) |-> cfg_q[POS_A_STATE+:2] == SHDN_TRISTATE && !out_a_q)
    else $error("output released outside tristate");
endmodule
bind wasc_top wasc_chk i_wasc_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .comparator1_async_output(comparator1_async_output),
  .comparator2_async_output(comparator2_async_output), .fault_input_pin_n(fault_input_pin_n),
  .out_a_q(out_a_q), .out_a_oe_q(out_a_oe_q), .out_b_q(out_b_q), .out_b_oe_q(out_b_oe_q)
);
`default_nettype wire

// ===== tb/wasc_src_model.sv
// comparator and fault pin model for the auto-shutdown block
// assumes sources change only on aclk edges
`timescale 1ns/1ps
`default_nettype none
module wasc_src_model
(
  input  wire logic       aclk,
  input  wire logic [2:0] req,
  input  wire logic       slow,
  output var  logic       comparator1_async_output,
  output var  logic       comparator2_async_output,
  output var  logic       fault_input_pin_n
);
  // slow mode adds one edge of lag, like a comparator near threshold
  logic [2:0] lag_q = 3'h0;
  logic [2:0] src;
  assign src = slow ? lag_q : req;
  initial
  begin
    comparator1_async_output = 1'b0;
    comparator2_async_output = 1'b0;
    fault_input_pin_n = 1'b1;
  end
  always @(posedge aclk)
  begin
    lag_q <= req;
    comparator1_async_output <= src[0];
    comparator2_async_output <= src[1];
    // pin idles high on its pull-up
    fault_input_pin_n <= !src[2];
  end
endmodule
`default_nettype wire

// ===== tb/tb_wasc_top.sv
// self-checking bench for the waveform auto-shutdown control block
// assumes wasc_top, the source model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_wasc_top
  import wasc_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, w1 = 1'b0, w2 = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [2:0]  req = 3'h0;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq, c1, c2, fn, oa, oae, ob, obe;
  int          fail_count = 0, n_tests = 0;
  wasc_top i_wasc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator1_async_output(c1),
    .comparator2_async_output(c2), .wave1_in(w1), .wave2_in(w2), .fault_input_pin_n(fn),
    .out_a_q(oa), .out_a_oe_q(oae), .out_b_q(ob), .out_b_oe_q(obe), .irq_q(irq)
  );
  wasc_src_model i_wasc_src_model (
    .aclk(aclk), .req(req), .slow(slow), .comparator1_async_output(c1),
    .comparator2_async_output(c2), .fault_input_pin_n(fn)
  );
  always #10 aclk = ~aclk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ==========
  // bus master: one transfer, ready raised only after valid is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    if (w)
    begin
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
    end
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (arready)
        arvalid <= 1'b0;
      bready <= bvalid && !bready;
      rready <= rvalid && !rready;
      n++;
    end while (!(bvalid && bready || rvalid && rready) && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      $display("[FAIL] handshake expected done seen timeout");
      finish_test();
    end
    chk(w ? "bresp" : "rresp", 32'(er), w ? 32'(bresp) : 32'(rresp));
    if (!w)
      chk("rdata", {24'h000000, d}, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d, RESP_OKAY);
  endtask
  task automatic src(input logic [2:0] v);
    req <= v;
    repeat (5) @(posedge aclk);
  endtask
  task automatic pins(input logic [1:0] ea, input logic [1:0] eb);
    chk("pin_a", 32'(ea), 32'({oae, oa}));
    chk("pin_b", 32'(eb), 32'({obe, ob}));
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
      rd(8'(4 * i), 8'h00);
    bus(1'b0, 8'h14, 8'h00, RESP_SLVERR);
    bus(1'b1, 8'h14, 8'hFF, RESP_SLVERR);
    // lane 0 off: answered OKAY, register untouched
    wstrb <= 4'hE;
    wr(OFS_DRV_CFG, 8'h5A);
    wstrb <= 4'hF;
    rd(OFS_DRV_CFG, 8'h00);
  endtask
  task automatic t_sources;
    logic [7:0] en [3];
    en = '{8'h04, 8'h08, 8'h02};
    wr(OFS_OUT_CFG, 8'hB0);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_SHDN_CTRL, en[(i + 1) % 3]);
      src(3'(1 << i));
      rd(OFS_SHDN_CTRL, en[(i + 1) % 3]);
      wr(OFS_SHDN_CTRL, en[i]);
      rd(OFS_SHDN_CTRL, en[i] | 8'h80);
      pins(2'b11, 2'b10);
      wr(OFS_SHDN_CTRL, en[i]);
      rd(OFS_SHDN_CTRL, en[i] | 8'h80);
      src(3'h0);
      wr(OFS_SHDN_CTRL, en[i]);
      rd(OFS_SHDN_CTRL, en[i]);
    end
  endtask
  task automatic t_states;
    logic [1:0] ex [4];
    ex = '{2'b11, 2'b00, 2'b10, 2'b11};
    slow <= 1'b1;
    wr(OFS_DRV_CFG, 8'h40);
    wr(OFS_SHDN_CTRL, 8'h04);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_OUT_CFG, 8'(s * 8'h50));
      src(3'h1);
      pins(ex[s], (s == 0) ? 2'b10 : ex[s]);
      src(3'h0);
      wr(OFS_SHDN_CTRL, 8'h04);
    end
    slow <= 1'b0;
    wr(OFS_DRV_CFG, 8'h00);
    wr(OFS_SHDN_CTRL, 8'h00);
  endtask
  task automatic t_select;
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_OUT_CFG, 8'(c));
      for (int v = 0; v < 2; v++)
      begin
        w1 <= (c == 2) && v;
        w2 <= (c == 3) && v;
        src((c < 2) ? 3'(v << c) : 3'h0);
        pins({1'b1, v[0]}, {1'b1, !v[0]});
      end
    end
  endtask
  task automatic t_irq;
    // earlier shutdowns left the entry bit set; clear it so the checks below mean something
    rd(OFS_IRQ_STAT, 8'h01);
    wr(OFS_IRQ_MASK, 8'h03);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_SHDN_CTRL, 8'h44);
    src(3'h1);
    chk("irq", 32'h1, 32'(irq));
    src(3'h0);
    rd(OFS_SHDN_CTRL, 8'h44);
    rd(OFS_IRQ_STAT, 8'h03);
    rd(OFS_IRQ_STAT, 8'h00);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_IRQ_MASK, 8'h00);
    src(3'h1);
    chk("irq", 32'h0, 32'(irq));
    src(3'h0);
    rd(OFS_IRQ_STAT, 8'h03);
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_sources();
    t_states();
    t_select();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
